// ---- logic/sif_regs.svh ----
//==============================================================
// Serial port constants
//==============================================================
// Purpose: Timing counts, field sizes and priority codes.
// Assumes: Included by its bare name.
// Notes:   Definitions only.
`ifndef SIF_REGS_SVH
`define SIF_REGS_SVH
`define SIF_OVERSAMPLE 16
`define SIF_SAMPLE_TICK 4'h7
`define SIF_BIT_LAST_TICK 4'hF
`define SIF_LAST_BIT 3'h7
`define SIF_SCK_HALF_LAST 3'h7
`define SIF_DIV_W 12
`define SIF_FIFO_DEPTH 16
`define SIF_TOP_NONE 3'h0
`define SIF_TOP_RX_ERR 3'h1
`define SIF_TOP_RX_FULL 3'h2
`define SIF_TOP_TX_EMPTY 3'h3
`define SIF_TOP_TX_END 3'h4
`endif

// ---- logic/sif_pkg.sv ----
//==============================================================
// Serial port types
//==============================================================
// Purpose: State and data types of the serial port.
// Assumes: Nothing.
// Notes:   Constants live in sif_regs.svh.
package sif_pkg;
   typedef logic [7:0] sif_byte_t;
   typedef enum {SIF_TX_IDLE, SIF_TX_START, SIF_TX_DATA, SIF_TX_PAR,
      SIF_TX_STOP} sif_tx_e;
   typedef enum {SIF_RX_IDLE, SIF_RX_START, SIF_RX_DATA, SIF_RX_PAR,
      SIF_RX_STOP, SIF_RX_DONE} sif_rx_e;
endpackage

// ---- logic/sif_stream_if.sv ----
//==============================================================
// Valid/ready byte stream
//==============================================================
// Purpose: Carries a word stream between the port and its FIFO.
// Assumes: Both ends on one clock.
// Notes:   A word moves when valid and ready are both high.
`timescale 1ns/100ps
interface sif_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ---- logic/sif_fifo.sv ----
//==============================================================
// Synchronous FIFO
//==============================================================
// Purpose: Buffers transmit words ahead of the transmit register.
// Assumes: DEPTH is a power of two.
// Notes:   Full and empty are registered.
`timescale 1ns/100ps
module sif_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Filling and draining sides.
   sif_stream_if.snk wr,
   sif_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wp, rp, next_wp, next_rp;
   logic full, empty, next_full, next_empty;
   logic push, pop;

   // Pointer and flag update; pointers carry one wrap bit.
   always_comb begin
      push = wr.valid & ~full;
      pop = rd.ready & ~empty;
      next_wp = push ? AW'(1) + wp : wp;
      next_rp = pop ? AW'(1) + rp : rp;
      next_empty = next_wp == next_rp;
      next_full = (next_wp[AW-1:0] == next_rp[AW-1:0]) &&
         (next_wp[AW] != next_rp[AW]);
   end

   // Registers the pointers and flags.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp <= '0;
         rp <= '0;
         full <= 1'b0;
         empty <= 1'b1;
      end else begin
         wp <= next_wp;
         rp <= next_rp;
         full <= next_full;
         empty <= next_empty;
      end
   end

   // Storage array; written only on an accepted push.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp[AW-1:0]] <= wr.data;
      end
   end

   assign wr.ready = ~full;
   assign rd.valid = ~empty;
   assign rd.data = mem[rp[AW-1:0]];
endmodule // sif_fifo

// ---- logic/sif_serial_port.sv ----
//==============================================================
// Serial port flags, requests and bit engines
//==============================================================
// Purpose: Status flags, request lines and serial engines.
// Assumes: Control bits and strobes come from the clk domain.
`timescale 1ns/100ps
`include "sif_regs.svh"
module sif_serial_port #(
   parameter int DIV_W = `SIF_DIV_W,
   parameter int FIFO_DEPTH = `SIF_FIFO_DEPTH
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Control bits.
   input wire logic tx_enable,
   input wire logic rx_enable,
   input wire logic tx_irq_enable,
   input wire logic rx_irq_enable,
   input wire logic tx_end_irq_enable,
   input wire logic sync_mode,
   input wire logic ext_clk,
   input wire logic parity_en,
   input wire logic parity_odd,
   input wire logic [DIV_W-1:0] base_div,
   // Transmit data from software and from dma; dma receive read.
   input wire logic cpu_tdr_wr,
   input wire sif_pkg::sif_byte_t cpu_tdr_data,
   input wire logic dma_wr_valid,
   input wire sif_pkg::sif_byte_t dma_wr_data,
   output logic dma_wr_ready,
   input wire logic dma_rx_rd,
   // Flag clear strobes.
   input wire logic clr_tx_empty,
   input wire logic clr_tx_end,
   input wire logic clr_rx_full,
   input wire logic clr_overrun,
   input wire logic clr_framing,
   input wire logic clr_parity,
   // Status.
   output logic tx_empty_flag,
   output logic tx_end_flag,
   output logic rx_full_flag,
   output logic overrun_flag,
   output logic framing_err_flag,
   output logic parity_err_flag,
   output sif_pkg::sif_byte_t rx_data_reg,
   // Request lines.
   output logic tx_end_irq,
   output logic rx_error_irq,
   output logic rx_full_irq,
   output logic tx_empty_irq,
   output logic [2:0] irq_top,
   // Serial pins.
   input wire logic rxd_in,
   input wire logic sck_in,
   output logic txd_out,
   output logic sck_out,
   output logic sck_oe
);
   import sif_pkg::*;

   sif_stream_if #(.W(8)) wr_if();
   sif_stream_if #(.W(8)) rd_if();
   sif_byte_t tx_data_reg, next_tdr, tx_shift_reg, next_tsr, rx_shift_reg, next_rsr;
   sif_tx_e tx_st, next_tx_st;
   sif_rx_e rx_st, next_rx_st;
   logic [DIV_W-1:0] base_cnt, next_base_cnt;
   logic [3:0] tx_tick, next_tx_tick, rx_tick, next_rx_tick;
   logic [2:0] tx_bit, next_tx_bit, rx_bit, next_rx_bit;
   logic [2:0] sck_cnt, next_sck_cnt, next_top;
   logic base_tick, next_base_tick, next_sck, next_sck_oe;
   logic rxd_s1, rxd_s2, sck_s1, sck_s2, sck_s3, rxd_prev, next_rxd_prev;
   logic int_run, int_evt, sck_rise, sck_fall, tx_bit_end;
   logic next_txd, tx_load, tx_end_set, dma_pop, err_any;
   logic brk, next_brk, rx_fer, next_rx_fer, rx_per, next_rx_per;
   logic rx_copy, rx_set_full, rx_set_ovr, rx_set_fer, rx_set_per;
   logic next_empty, next_end, next_full, next_ovr, next_fer, next_per;
   sif_byte_t next_rdr;

   // The FIFO drains only while the transmit register is empty.
   sif_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .wr(wr_if.snk),
      .rd(rd_if.src)
   );
   assign wr_if.valid = dma_wr_valid;
   assign wr_if.data = dma_wr_data;
   assign dma_wr_ready = wr_if.ready;
   assign rd_if.ready = tx_empty_flag & tx_enable & ~cpu_tdr_wr;
   assign dma_pop = rd_if.valid & rd_if.ready;
   assign err_any = overrun_flag | framing_err_flag | parity_err_flag;

   //===========================================================
   // Base clock, serial clock and pin synchronisers
   //===========================================================
   // Internal serial clock runs only while a frame is moving.
   always_comb begin
      next_base_tick = base_cnt == base_div;
      next_base_cnt = next_base_tick ? '0 : base_cnt + DIV_W'(1);
      int_run = sync_mode & ~ext_clk &
         (tx_st != SIF_TX_IDLE || rx_st == SIF_RX_DATA);
      int_evt = int_run & base_tick & (sck_cnt == `SIF_SCK_HALF_LAST);
      next_sck_cnt = !int_run ? 3'h0 : base_tick ? sck_cnt + 3'h1 : sck_cnt;
      next_sck = !int_run ? 1'b1 : int_evt ? ~sck_out : sck_out;
      next_sck_oe = sync_mode & ~ext_clk;
      sck_rise = ext_clk ? (sck_s2 & ~sck_s3) : (int_evt & ~sck_out);
      sck_fall = ext_clk ? (~sck_s2 & sck_s3) : (int_evt & sck_out);
   end

   // Registers clock state; pins pass two flip-flops first.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         base_cnt <= '0;
         base_tick <= 1'b0;
         sck_cnt <= 3'h0;
         sck_out <= 1'b1;
         sck_oe <= 1'b0;
         rxd_s1 <= 1'b1;
         rxd_s2 <= 1'b1;
         sck_s1 <= 1'b1;
         sck_s2 <= 1'b1;
         sck_s3 <= 1'b1;
      end else begin
         base_cnt <= next_base_cnt;
         base_tick <= next_base_tick;
         sck_cnt <= next_sck_cnt;
         sck_out <= next_sck;
         sck_oe <= next_sck_oe;
         rxd_s1 <= rxd_in;
         rxd_s2 <= rxd_s1;
         sck_s1 <= sck_in;
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
      end
   end

   //===========================================================
   // Transmitter
   //===========================================================
   // Loads the shift register, shifts bits out and ends frames.
   always_comb begin
      next_tx_st = tx_st;
      next_tx_tick = base_tick ? tx_tick + 4'h1 : tx_tick;
      next_tx_bit = tx_bit;
      next_tsr = tx_shift_reg;
      next_txd = txd_out;
      tx_end_set = 1'b0;
      tx_bit_end = base_tick & (tx_tick == `SIF_BIT_LAST_TICK);
      tx_load = (tx_st == SIF_TX_IDLE) & tx_enable & ~tx_empty_flag &
         ~(sync_mode & err_any);
      case (tx_st)
         SIF_TX_IDLE: begin
            next_tx_tick = 4'h0;
            next_txd = sync_mode ? txd_out : 1'b1;
            if (tx_load) begin
               next_tsr = tx_data_reg;
               next_tx_bit = 3'h0;
               next_tx_st = sync_mode ? SIF_TX_DATA : SIF_TX_START;
               next_txd = sync_mode ? tx_data_reg[0] : 1'b0;
            end
         end
         SIF_TX_START: begin
            if (tx_bit_end) begin
               next_tx_st = SIF_TX_DATA;
               next_txd = tx_shift_reg[0];
            end
         end
         SIF_TX_DATA: begin
            if (sync_mode) begin
               if (sck_fall && tx_bit != 3'h0) begin
                  next_txd = tx_shift_reg[tx_bit];
                  tx_end_set = (tx_bit == `SIF_LAST_BIT) & tx_empty_flag;
               end
               if (sck_rise) begin
                  next_tx_bit = tx_bit + 3'h1;
                  if (tx_bit == `SIF_LAST_BIT) begin
                     next_tx_st = SIF_TX_IDLE;
                  end
               end
            end else if (tx_bit_end) begin
               if (tx_bit == `SIF_LAST_BIT) begin
                  next_tx_st = parity_en ? SIF_TX_PAR : SIF_TX_STOP;
                  next_txd = parity_en ? (^tx_shift_reg ^ parity_odd) : 1'b1;
                  tx_end_set = ~parity_en & tx_empty_flag;
               end else begin
                  next_tx_bit = tx_bit + 3'h1;
                  next_txd = tx_shift_reg[3'(tx_bit + 3'h1)];
               end
            end
         end
         SIF_TX_PAR: begin
            if (tx_bit_end) begin
               next_tx_st = SIF_TX_STOP;
               next_txd = 1'b1;
               tx_end_set = tx_empty_flag;
            end
         end
         SIF_TX_STOP: begin
            if (tx_bit_end) begin
               next_tx_st = SIF_TX_IDLE;
            end
         end
         default: next_tx_st = SIF_TX_IDLE;
      endcase
      if (!tx_enable) begin
         next_tx_st = SIF_TX_IDLE;
         next_tx_bit = 3'h0;
         next_txd = 1'b1;
      end
   end

   // Registers the transmitter.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_st <= SIF_TX_IDLE;
         tx_tick <= 4'h0;
         tx_bit <= 3'h0;
         tx_shift_reg <= 8'h00;
         txd_out <= 1'b1;
      end else begin
         tx_st <= next_tx_st;
         tx_tick <= next_tx_tick;
         tx_bit <= next_tx_bit;
         tx_shift_reg <= next_tsr;
         txd_out <= next_txd;
      end
   end

   //===========================================================
   // Receiver
   //===========================================================
   // Finds the start edge, samples mid-bit and closes the frame.
   always_comb begin
      next_rx_st = rx_st;
      next_rx_tick = base_tick ? rx_tick + 4'h1 : rx_tick;
      next_rx_bit = rx_bit;
      next_rsr = rx_shift_reg;
      next_brk = brk;
      next_rx_fer = rx_fer;
      next_rx_per = rx_per;
      next_rxd_prev = base_tick ? rxd_s2 : rxd_prev;
      rx_copy = 1'b0;
      rx_set_full = 1'b0;
      rx_set_ovr = 1'b0;
      rx_set_fer = 1'b0;
      rx_set_per = 1'b0;
      case (rx_st)
         SIF_RX_IDLE: begin
            next_rx_tick = 4'h0;
            next_rx_bit = 3'h0;
            next_rx_fer = 1'b0;
            next_rx_per = 1'b0;
            if (sync_mode) begin
               if (rx_enable && !err_any) begin
                  next_rx_st = SIF_RX_DATA;
               end
            end else if (rx_enable && base_tick && !rxd_s2 &&
                  (rxd_prev || brk)) begin
               next_rx_st = SIF_RX_START;
            end
         end
         SIF_RX_START: begin
            if (base_tick && rx_tick == `SIF_SAMPLE_TICK) begin
               next_rx_tick = 4'h0;
               next_rx_st = rxd_s2 ? SIF_RX_IDLE : SIF_RX_DATA;
            end
         end
         SIF_RX_DATA: begin
            if (sync_mode ? sck_rise :
                  (base_tick && rx_tick == `SIF_BIT_LAST_TICK)) begin
               next_rsr = {rxd_s2, rx_shift_reg[7:1]};
               next_rx_bit = rx_bit + 3'h1;
               if (rx_bit == `SIF_LAST_BIT) begin
                  next_rx_st = sync_mode ? SIF_RX_DONE :
                     parity_en ? SIF_RX_PAR : SIF_RX_STOP;
               end
            end
         end
         SIF_RX_PAR: begin
            if (base_tick && rx_tick == `SIF_BIT_LAST_TICK) begin
               next_rx_per = rxd_s2 != (^rx_shift_reg ^ parity_odd);
               next_rx_st = SIF_RX_STOP;
            end
         end
         SIF_RX_STOP: begin
            if (base_tick && rx_tick == `SIF_BIT_LAST_TICK) begin
               next_rx_fer = ~rxd_s2;
               next_brk = ~rxd_s2;
               next_rx_st = SIF_RX_DONE;
            end
         end
         SIF_RX_DONE: begin
            next_rx_st = SIF_RX_IDLE;
            if (!rx_enable) begin
               rx_set_full = 1'b1;
            end else if (rx_full_flag) begin
               rx_set_ovr = 1'b1;
               rx_set_fer = rx_fer;
               rx_set_per = rx_per;
            end else begin
               rx_copy = 1'b1;
               rx_set_fer = rx_fer;
               rx_set_per = rx_per;
               rx_set_full = ~(rx_fer | rx_per);
            end
         end
         default: next_rx_st = SIF_RX_IDLE;
      endcase
      if (!rx_enable && rx_st != SIF_RX_DONE) begin
         next_rx_st = SIF_RX_IDLE;
      end
   end

   // Registers the receiver.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_st <= SIF_RX_IDLE;
         rx_tick <= 4'h0;
         rx_bit <= 3'h0;
         rx_shift_reg <= 8'h00;
         brk <= 1'b0;
         rx_fer <= 1'b0;
         rx_per <= 1'b0;
         rxd_prev <= 1'b1;
      end else begin
         rx_st <= next_rx_st;
         rx_tick <= next_rx_tick;
         rx_bit <= next_rx_bit;
         rx_shift_reg <= next_rsr;
         brk <= next_brk;
         rx_fer <= next_rx_fer;
         rx_per <= next_rx_per;
         rxd_prev <= next_rxd_prev;
      end
   end

   //===========================================================
   // Status flags, data registers and request lines
   //===========================================================
   // Every flag lets a set in the same cycle beat its clear.
   always_comb begin
      next_tdr = cpu_tdr_wr ? cpu_tdr_data :
         dma_pop ? rd_if.data : tx_data_reg;
      next_empty = (tx_empty_flag & ~clr_tx_empty & ~dma_pop) |
         tx_load | ~tx_enable;
      next_end = (tx_end_flag & ~clr_tx_end & ~tx_load) |
         tx_end_set | ~tx_enable;
      next_full = (rx_full_flag & ~clr_rx_full & ~dma_rx_rd) |
         rx_set_full;
      next_ovr = (overrun_flag & ~clr_overrun) | rx_set_ovr;
      next_fer = (framing_err_flag & ~clr_framing) | rx_set_fer;
      next_per = (parity_err_flag & ~clr_parity) | rx_set_per;
      next_rdr = rx_copy ? rx_shift_reg : rx_data_reg;
      if (next_ovr | next_fer | next_per && rx_irq_enable) begin
         next_top = `SIF_TOP_RX_ERR;
      end else if (next_full && rx_irq_enable) begin
         next_top = `SIF_TOP_RX_FULL;
      end else if (next_empty && tx_irq_enable) begin
         next_top = `SIF_TOP_TX_EMPTY;
      end else if (next_end && tx_end_irq_enable) begin
         next_top = `SIF_TOP_TX_END;
      end else begin
         next_top = `SIF_TOP_NONE;
      end
   end

   // Registers flags and drives each request on its own line.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_data_reg <= 8'hFF;
         tx_empty_flag <= 1'b1;
         tx_end_flag <= 1'b1;
         rx_full_flag <= 1'b0;
         overrun_flag <= 1'b0;
         framing_err_flag <= 1'b0;
         parity_err_flag <= 1'b0;
         rx_data_reg <= 8'h00;
         tx_empty_irq <= 1'b0;
         tx_end_irq <= 1'b0;
         rx_full_irq <= 1'b0;
         rx_error_irq <= 1'b0;
         irq_top <= `SIF_TOP_NONE;
      end else begin
         tx_data_reg <= next_tdr;
         tx_empty_flag <= next_empty;
         tx_end_flag <= next_end;
         rx_full_flag <= next_full;
         overrun_flag <= next_ovr;
         framing_err_flag <= next_fer;
         parity_err_flag <= next_per;
         rx_data_reg <= next_rdr;
         tx_empty_irq <= next_empty & tx_irq_enable;
         tx_end_irq <= next_end & tx_end_irq_enable;
         rx_full_irq <= next_full & rx_irq_enable;
         rx_error_irq <= (next_ovr | next_fer | next_per) &
            rx_irq_enable;
         irq_top <= next_top;
      end
   end
endmodule // sif_serial_port

// ---- bench/sif_properties.sv ----
//====================
// Serial port checker
//====================
// Purpose: Request lines, priority code and flag relations.
// Assumes: Bound to sif_serial_port; one clock domain.
// Notes:   Requests follow flags on the edge that moves the flags.
`timescale 1ns/100ps
`include "sif_regs.svh"
module sif_props (
   // Clock, reset and controls.
   input wire logic clk, rst_n, tx_enable, rx_enable, clr_overrun,
   input wire logic tx_irq_enable, rx_irq_enable, tx_end_irq_enable,
   input wire logic dma_rx_rd,
   // Flags and requests.
   input wire logic tx_empty_flag, tx_end_flag, rx_full_flag,
   input wire logic overrun_flag, framing_err_flag, parity_err_flag,
   input wire logic tx_end_irq, rx_error_irq, rx_full_irq, tx_empty_irq,
   input wire logic [2:0] irq_top
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic err;
   logic [2:0] top;
   // Any error flag feeds the error request.
   assign err = overrun_flag | framing_err_flag | parity_err_flag;
   // Highest pending request gives the expected code.
   always_comb begin
      if (rx_error_irq) top = `SIF_TOP_RX_ERR;
      else if (rx_full_irq) top = `SIF_TOP_RX_FULL;
      else if (tx_empty_irq) top = `SIF_TOP_TX_EMPTY;
      else if (tx_end_irq) top = `SIF_TOP_TX_END;
      else top = `SIF_TOP_NONE;
   end
   a_err_gate: assert property (
      rx_error_irq == (err & $past(rx_irq_enable)))
      else $error("error request mismatch");
   a_full_gate: assert property (
      rx_full_irq == (rx_full_flag & $past(rx_irq_enable)))
      else $error("full request mismatch");
   a_empty_gate: assert property (
      tx_empty_irq == (tx_empty_flag & $past(tx_irq_enable)))
      else $error("empty request mismatch");
   a_end_gate: assert property (
      tx_end_irq == (tx_end_flag & $past(tx_end_irq_enable)))
      else $error("end request mismatch");
   a_top_rank: assert property (irq_top == top)
      else $error("priority code mismatch");
   a_full_clear: assert property (dma_rx_rd |=> !rx_full_flag)
      else $error("full flag kept after dma read");
   a_txen_init: assert property (
      $fell(tx_enable) |=> tx_empty_flag && tx_end_flag)
      else $error("transmitter not initialised");
   a_rxen_keep: assert property (
      $fell(rx_enable) && !clr_overrun |=> !$past(overrun_flag) ||
      overrun_flag) else $error("overrun lost on receive disable");
   a_end_cause: assert property (
      $rose(tx_end_flag) && $past(tx_enable) |-> $past(tx_empty_flag))
      else $error("end set while data pending");
   c_err: cover property ($rose(rx_error_irq));
   c_end: cover property ($rose(tx_end_irq));
   c_full: cover property (rx_full_irq && irq_top == `SIF_TOP_RX_FULL);
endmodule // sif_props
bind sif_serial_port sif_props sif_props_i (.*);

// ---- bench/sif_peer.sv ----
//====================
// Serial peer model
//====================
// Purpose: Sends frames to the port and decodes what it sends.
// Assumes: One bit lasts BIT ns.
// Notes:   Its serial clock stands high outside frames.
`timescale 1ns/100ps
module sif_peer #(parameter real BIT = 128.0) (
   // Serial lines.
   input wire logic txd_out,
   input wire logic sck_run,
   output logic rxd_in,
   output logic sck_in
);
   logic [7:0] got[$];
   logic [7:0] sh;
   // Lines idle high.
   initial begin
      rxd_in = 1'b1;
      sck_in = 1'b1;
   end
   // One frame, low start, LSB first, stop level chosen by caller.
   task automatic send(input logic [7:0] d, input logic stop);
      rxd_in = 1'b0;
      #(BIT);
      for (int i = 0; i < 8; i++) begin
         rxd_in = d[i];
         #(BIT);
      end
      rxd_in = stop;
      #(BIT);
      rxd_in = 1'b1;
      #(BIT);
   endtask
   // Samples each transmitted bit at its middle.
   always @(negedge txd_out) begin
      #(BIT * 1.5);
      for (int i = 0; i < 8; i++) begin
         sh[i] = txd_out;
         #(BIT);
      end
      got.push_back(sh);
   end
   // The 125 ns clock runs only while asked, ending high.
   always begin
      wait (sck_run);
      #62.5 sck_in = 1'b0;
      #62.5 sck_in = 1'b1;
   end
endmodule // sif_peer

// ---- bench/sif_serial_port_bench.sv ----
//====================
// Serial port bench
//====================
// Purpose: Drives the port and its peer, checks the flags.
// Assumes: base_div of 1, so one bit is 32 clocks.
// Notes:   Random bytes come from a fixed seed.
`timescale 1ns/100ps
`include "sif_regs.svh"
module sif_serial_port_bench;
   import sif_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, tx_enable = 1'b0, rx_enable = 1'b0;
   logic tx_irq_enable = 1'b0, rx_irq_enable = 1'b0, sck_run = 1'b0;
   logic tx_end_irq_enable = 1'b0, sync_mode = 1'b0, ext_clk = 1'b0;
   logic parity_en = 1'b0, parity_odd = 1'b0, cpu_tdr_wr = 1'b0;
   logic dma_wr_valid = 1'b0, dma_rx_rd = 1'b0, clr_tx_empty = 1'b0;
   logic clr_tx_end = 1'b0, clr_rx_full = 1'b0, clr_overrun = 1'b0;
   logic clr_framing = 1'b0, clr_parity = 1'b0;
   logic [11:0] base_div = 12'h001;
   sif_byte_t cpu_tdr_data = 8'h00, dma_wr_data = 8'h00, rx_data_reg, b;
   logic dma_wr_ready, tx_empty_flag, tx_end_flag, rx_full_flag, sck_in;
   logic overrun_flag, framing_err_flag, parity_err_flag, tx_end_irq;
   logic rx_error_irq, rx_full_irq, tx_empty_irq, txd_out, sck_out;
   logic sck_oe, rxd_in;
   logic [2:0] irq_top;
   sif_byte_t q[$];
   int n_errors = 0, total_checks = 0, k;
   sif_serial_port sif_serial_port_i (.*);
   sif_peer sif_peer_i (.txd_out(txd_out), .sck_run(sck_run),
      .rxd_in(rxd_in), .sck_in(sck_in));
   // The 250 MHz clock.
   initial forever #2 clk = ~clk;
   // Compares one value and counts it.
   task automatic chk(input string nm, input logic [7:0] s, e);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value %s: expected %h seen %h", nm, e, s);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Main sequence.
   initial begin
      void'($urandom(32'hab1daf77));
      cyc(2);
      rst_n <= 1'b1;
      @(negedge clk);
      chk("empty", tx_empty_flag, 1'b1);
      chk("end", tx_end_flag, 1'b1);
      chk("txd", txd_out, 1'b1);
      $display("reset test done");
      cyc(1);
      tx_enable <= 1'b1;
      tx_irq_enable <= 1'b1;
      tx_end_irq_enable <= 1'b1;
      dma_wr_valid <= 1'b1;
      dma_wr_data <= 8'($urandom);
      for (k = 0; k < 40; k++) begin
         @(negedge clk);
         if (!dma_wr_ready) break;
         q.push_back(dma_wr_data);
         cyc(1);
         dma_wr_data <= 8'($urandom);
      end
      cyc(1);
      dma_wr_valid <= 1'b0;
      chk("fill", 8'(q.size()), 8'(`SIF_FIFO_DEPTH + 2));
      for (k = 0; k < 20000 && sif_peer_i.got.size() < q.size(); k++)
         cyc(1);
      if (k >= 20000) begin
         n_errors++;
         finish_test();
      end
      cyc(100);
      @(negedge clk);
      foreach (q[i]) chk("byte", sif_peer_i.got[i], q[i]);
      chk("end", tx_end_irq, 1'b1);
      chk("empty", tx_empty_irq, 1'b1);
      chk("top", irq_top, `SIF_TOP_TX_EMPTY);
      $display("transmit test done");
      cyc(1);
      tx_irq_enable <= 1'b0;
      tx_end_irq_enable <= 1'b0;
      rx_enable <= 1'b1;
      rx_irq_enable <= 1'b1;
      cyc(5);
      b = 8'($urandom);
      sif_peer_i.send(b, 1'b1);
      cyc(20);
      @(negedge clk);
      chk("data", rx_data_reg, b);
      chk("full", rx_full_irq, 1'b1);
      chk("top", irq_top, `SIF_TOP_RX_FULL);
      sif_peer_i.send(~b, 1'b1);
      cyc(20);
      @(negedge clk);
      chk("overrun", overrun_flag, 1'b1);
      chk("full", rx_full_flag, 1'b1);
      chk("data", rx_data_reg, b);
      chk("top", irq_top, `SIF_TOP_RX_ERR);
      cyc(1);
      rx_enable <= 1'b0;
      cyc(40);
      @(negedge clk);
      chk("overrun", overrun_flag, 1'b1);
      cyc(1);
      clr_overrun <= 1'b1;
      dma_rx_rd <= 1'b1;
      rx_enable <= 1'b1;
      cyc(1);
      clr_overrun <= 1'b0;
      dma_rx_rd <= 1'b0;
      cyc(5);
      b = 8'($urandom);
      sif_peer_i.send(b, 1'b0);
      cyc(20);
      @(negedge clk);
      chk("framing", framing_err_flag, 1'b1);
      chk("full", rx_full_flag, 1'b0);
      chk("data", rx_data_reg, b);
      sif_peer_i.rxd_in = 1'b0;
      cyc(1);
      clr_framing <= 1'b1;
      cyc(1);
      clr_framing <= 1'b0;
      cyc(400);
      @(negedge clk);
      chk("break", framing_err_flag, 1'b1);
      $display("receive test done");
      sif_peer_i.rxd_in = 1'b1;
      cyc(1);
      rx_enable <= 1'b0;
      sync_mode <= 1'b1;
      ext_clk <= 1'b1;
      tx_enable <= 1'b0;
      cyc(2);
      tx_enable <= 1'b1;
      cyc(1);
      dma_wr_valid <= 1'b1;
      dma_wr_data <= 8'($urandom);
      cyc(1);
      dma_wr_valid <= 1'b0;
      cyc(5);
      sck_run <= 1'b1;
      cyc(300);
      sck_run <= 1'b0;
      @(negedge clk);
      chk("blocked", tx_empty_flag, 1'b0);
      cyc(40);
      clr_framing <= 1'b1;
      clr_tx_end <= 1'b1;
      cyc(1);
      clr_framing <= 1'b0;
      clr_tx_end <= 1'b0;
      cyc(10);
      @(negedge clk);
      chk("loaded", tx_empty_flag, 1'b1);
      chk("end", tx_end_flag, 1'b0);
      cyc(1);
      sck_run <= 1'b1;
      cyc(245);
      sck_run <= 1'b0;
      @(negedge clk);
      chk("end", tx_end_flag, 1'b1);
      cyc(40);
      ext_clk <= 1'b0;
      cpu_tdr_wr <= 1'b1;
      cpu_tdr_data <= 8'($urandom);
      clr_tx_empty <= 1'b1;
      clr_tx_end <= 1'b1;
      cyc(1);
      cpu_tdr_wr <= 1'b0;
      clr_tx_empty <= 1'b0;
      clr_tx_end <= 1'b0;
      cyc(300);
      @(negedge clk);
      chk("end", tx_end_flag, 1'b1);
      chk("sck", sck_out, 1'b1);
      chk("sck_oe", sck_oe, 1'b1);
      $display("synchronous test done");
      cyc(1);
      sync_mode <= 1'b0;
      cpu_tdr_wr <= 1'b1;
      clr_tx_empty <= 1'b1;
      clr_tx_end <= 1'b1;
      cyc(1);
      cpu_tdr_wr <= 1'b0;
      clr_tx_empty <= 1'b0;
      clr_tx_end <= 1'b0;
      cyc(60);
      tx_enable <= 1'b0;
      cyc(3);
      @(negedge clk);
      chk("end", tx_end_flag, 1'b1);
      chk("txd", txd_out, 1'b1);
      $display("disable test done");
      finish_test();
   end
endmodule // sif_serial_port_bench
